// ### pkg/frame_ctrl_pkg.sv
// package: register map, field layout, timing and carriers of the frame control block
`default_nettype none
package frame_ctrl_pkg;
	// register indices; byte address on the bus is four times the index
	localparam logic [5:0] IDX_EXT_LOW = 6'h08;
	localparam logic [5:0] IDX_EXT_MID = 6'h09;
	localparam logic [5:0] IDX_EXT_HIGH = 6'h0A;
	localparam logic [5:0] IDX_FRAME_CTRL = 6'h0C;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h11;
	localparam logic [5:0] IDX_RSSI = 6'h12;

	// reset values
	localparam logic [7:0] EXT_RESET = 8'h00;
	localparam logic [7:0] FRAME_CTRL_RESET = 8'h40;
	localparam logic [7:0] RSSI_FLOOR = 8'h80;

	// frame control field positions
	localparam int FC_APPEND = 7;
	localparam int FC_HW_CRC = 6;
	localparam int FC_AUTO_ACK = 5;
	localparam int FC_PEAK_HOLD = 4;
	localparam int FC_RX_MODE_LSB = 2;
	localparam int FC_TX_MODE_LSB = 0;

	// receive and transmit mode encodings
	localparam logic [1:0] RX_NORMAL = 2'h0;
	localparam logic [1:0] RX_LOOP = 2'h2;
	localparam logic [1:0] RX_NO_SEARCH = 2'h3;
	localparam logic [1:0] TX_NORMAL = 2'h0;
	localparam logic [1:0] TX_LOOP = 2'h2;
	localparam logic [1:0] TX_PRBS = 2'h3;

	// interrupt status bit positions
	localparam int IRQ_W = 4;
	localparam int IRQ_RX_DONE = 0;
	localparam int IRQ_CRC_FAIL = 1;
	localparam int IRQ_TX_UNDERFLOW = 2;
	localparam int IRQ_ACK = 3;

	// crc-16 itu-t, bit-reversed polynomial, and the pseudo-random seed
	localparam logic [15:0] CRC_POLY_REV = 16'h8408;
	localparam logic [15:0] PRBS_SEED = 16'hFFFF;

	// acknowledgement delay: 12 symbols of 16 us
	localparam int ACK_DELAY_US = 192;
	localparam int CLK_PERIOD_NS = 4;
	localparam int ACK_DELAY_CYCLES = ACK_DELAY_US * 1000 / CLK_PERIOD_NS;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} byte_in_s;

	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} byte_out_s;

	typedef struct packed {
		logic [7:0] rssi;
		logic [6:0] correlation;
		logic [6:0] source_match_result_index;
		logic accepted;
		logic ackRequested;
	} rx_info_s;
endpackage
`default_nettype wire

// ### verilog/frame_handling_control.sv
// frame handling control: match enables, frame control, rx status append, tx crc, auto ack
//
// Implementation choice: register access over Wishbone.
`default_nettype none
// Functional notes
// R01 - Hold twelve extended-entry match enables behind a 24-bit word.
// R02 - Word spread over three byte registers, low, mid, high, at rising addresses.
// R03 - Writes take entry n from bit 2n only; odd bits ignore writes.
// R04 - Reads return each entry's enable on both bits 2n and 2n+1.
// R05 - Host clears an entry's enable while rewriting that entry.
// R06 - Append select has no effect while hardware crc is off.
// R07 - Crc on, append 0: append rssi, then crc-pass flag with correlation.
// R08 - Crc on, append 1: append rssi, then crc-pass flag with match index.
// R09 - Crc on in transmit: generate crc-16 and append its two bytes.
// R10 - Crc off in transmit: host supplies last two bytes, else underflow.
// R11 - Crc on in receive: check crc, store status word in its place.
// R12 - Crc off in receive: store received crc bytes unchanged.
// R13 - Crc setting does not alter acknowledgement frame transmission.
// R14 - Auto ack: accepted, ack-requested, crc-good frames acked 12 symbols later.
// R15 - Peak-hold 0 reports latest signal strength, 1 reports peak since set.
// R16 - Rx mode: normal, reserved, fifo looping, or symbol search disabled.
// R17 - Tx mode: normal, reserved, cyclic fifo looping, or pseudo-random data.
module frame_handling_control #(
	parameter int ACK_CYCLES = frame_ctrl_pkg::ACK_DELAY_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire frame_ctrl_pkg::byte_in_s rxIn,
	input wire frame_ctrl_pkg::rx_info_s rxInfo,
	output frame_ctrl_pkg::byte_out_s rxOut,
	input wire logic rssiValid,
	input wire logic [7:0] rssiSample,
	input wire frame_ctrl_pkg::byte_in_s transmit_fifo,
	output logic txFifoPop,
	input wire logic txByteReq,
	output frame_ctrl_pkg::byte_out_s txOut,
	output logic [11:0] extMatchEnable,
	output logic rxFifoLoop,
	output logic symbolSearchOff,
	output logic txFifoLoop,
	output logic ackStart,
	output logic irq
);
	// one crc-16 step over a byte, lsb first
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[0] ^ d[i]) begin
				r = (r >> 1) ^ frame_ctrl_pkg::CRC_POLY_REV;
			end else begin
				r = r >> 1;
			end
		end
		return r;
	endfunction

	// read view of one byte of the enable word: each entry shown twice
	function automatic logic [7:0] ext_read(input logic [3:0] en);
		logic [7:0] r;
		r = '0;
		for (int j = 0; j < 4; j++) begin
			r[2*j] = en[j];
			r[2*j+1] = en[j];
		end
		return r;
	endfunction

	// write view: only the even bits carry enables
	function automatic logic [3:0] ext_write(input logic [7:0] b);
		logic [3:0] r;
		r = '0;
		for (int j = 0; j < 4; j++) begin
			r[j] = b[2*j];
		end
		return r;
	endfunction

	logic [11:0] extEnable_reg;
	logic [7:0] frameCtrl_reg, rssi_reg, wrByte, rdData;
	logic [frame_ctrl_pkg::IRQ_W-1:0] irqStatus_reg, irqMask_reg, irqEvent;
	logic peakSel_reg, busReq, busWrite, hwCrc, appendSel, autoAck, peakHold;
	logic [5:0] idx;
	logic [1:0] rxMode, txMode;
	logic [6:0] rxPos_reg, rxLen_reg, txPos_reg, txPos_next, txLen_reg, txLen_next;
	logic [15:0] rxCrc_reg, rxCrcNow, txCrc_reg, txCrc_next;
	logic rxEnd, crcOk, txUnder, ackArm, ackFire;
	frame_ctrl_pkg::byte_out_s rxOut_next, txOut_next;
	logic [31:0] ackCount_reg;

	// field view of the frame control register
	assign hwCrc = frameCtrl_reg[frame_ctrl_pkg::FC_HW_CRC];
	assign appendSel = frameCtrl_reg[frame_ctrl_pkg::FC_APPEND];
	assign autoAck = frameCtrl_reg[frame_ctrl_pkg::FC_AUTO_ACK];
	assign peakHold = frameCtrl_reg[frame_ctrl_pkg::FC_PEAK_HOLD];
	assign rxMode = frameCtrl_reg[frame_ctrl_pkg::FC_RX_MODE_LSB +: 2];
	assign txMode = frameCtrl_reg[frame_ctrl_pkg::FC_TX_MODE_LSB +: 2];

	// mode outputs; the reserved codes 01 behave as normal operation
	assign rxFifoLoop = (rxMode == frame_ctrl_pkg::RX_LOOP); // see R16
	assign symbolSearchOff = (rxMode == frame_ctrl_pkg::RX_NO_SEARCH); // see R16
	assign txFifoLoop = (txMode == frame_ctrl_pkg::TX_LOOP); // see R17
	assign extMatchEnable = extEnable_reg; // see R01
	assign irq = |(irqStatus_reg & irqMask_reg);

	// bus decode; the write lands on the edge where the master sees ack
	assign idx = adr_i[7:2];
	assign busReq = cyc_i & stb_i;
	assign busWrite = busReq & ack_o & we_i & sel_i[0];
	assign wrByte = dat_i[7:0];

	// read mux; unmapped indices read as zero
	always_comb begin
		rdData = '0;
		if (idx == frame_ctrl_pkg::IDX_EXT_LOW) begin
			rdData = ext_read(extEnable_reg[3:0]); // see R02, R04
		end else if (idx == frame_ctrl_pkg::IDX_EXT_MID) begin
			rdData = ext_read(extEnable_reg[7:4]); // see R04
		end else if (idx == frame_ctrl_pkg::IDX_EXT_HIGH) begin
			rdData = ext_read(extEnable_reg[11:8]); // see R04
		end else if (idx == frame_ctrl_pkg::IDX_FRAME_CTRL) begin
			rdData = frameCtrl_reg;
		end else if (idx == frame_ctrl_pkg::IDX_IRQ_STATUS) begin
			rdData = {4'h0, irqStatus_reg};
		end else if (idx == frame_ctrl_pkg::IDX_IRQ_MASK) begin
			rdData = {4'h0, irqMask_reg};
		end else if (idx == frame_ctrl_pkg::IDX_RSSI) begin
			rdData = rssi_reg;
		end
	end

	// wishbone handshake: ack one cycle after the request, dropped the cycle after
	always_ff @(posedge mclk) begin
		if (rst) begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= busReq & ~ack_o;
			if (busReq & ~ack_o) begin
				dat_o <= {24'h00_0000, rdData};
			end
		end
	end

	// match enables: only even bits are stored, so odd bits cannot diverge
	always_ff @(posedge mclk) begin
		if (rst) begin
			extEnable_reg <= {3{frame_ctrl_pkg::EXT_RESET[3:0]}};
		end else if (busWrite) begin
			if (idx == frame_ctrl_pkg::IDX_EXT_LOW) begin
				extEnable_reg[3:0] <= ext_write(wrByte); // see R03
			end else if (idx == frame_ctrl_pkg::IDX_EXT_MID) begin
				extEnable_reg[7:4] <= ext_write(wrByte); // see R02, R03
			end else if (idx == frame_ctrl_pkg::IDX_EXT_HIGH) begin
				extEnable_reg[11:8] <= ext_write(wrByte); // see R02, R03
			end
		end
	end

	// frame control and interrupt mask registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			frameCtrl_reg <= frame_ctrl_pkg::FRAME_CTRL_RESET;
			irqMask_reg <= '0;
		end else if (busWrite) begin
			if (idx == frame_ctrl_pkg::IDX_FRAME_CTRL) begin
				frameCtrl_reg <= wrByte;
			end else if (idx == frame_ctrl_pkg::IDX_IRQ_MASK) begin
				irqMask_reg <= wrByte[frame_ctrl_pkg::IRQ_W-1:0];
			end
		end
	end

	// sticky status, write one to clear; a new event wins over its clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			irqStatus_reg <= '0;
		end else if (busWrite && idx == frame_ctrl_pkg::IDX_IRQ_STATUS) begin
			irqStatus_reg <= (irqStatus_reg & ~wrByte[frame_ctrl_pkg::IRQ_W-1:0]) | irqEvent;
		end else begin
			irqStatus_reg <= irqStatus_reg | irqEvent;
		end
	end

	// signal strength: latest sample, or peak since the hold bit rose
	always_ff @(posedge mclk) begin
		if (rst) begin
			rssi_reg <= frame_ctrl_pkg::RSSI_FLOOR;
			peakSel_reg <= 1'b0;
		end else begin
			peakSel_reg <= peakHold;
			if (peakHold & ~peakSel_reg) begin
				rssi_reg <= rssiValid ? rssiSample : frame_ctrl_pkg::RSSI_FLOOR; // see R15
			end else if (rssiValid) begin
				if (!peakHold || $signed(rssiSample) > $signed(rssi_reg)) begin
					rssi_reg <= rssiSample; // see R15
				end
			end
		end
	end

	// receive side: first byte is the length, the last two payload bytes are the crc
	assign rxCrcNow = crc_step(rxCrc_reg, rxIn.data);
	assign rxEnd = rxIn.valid && rxPos_reg != 7'd0 && rxPos_reg == rxLen_reg;
	assign crcOk = (rxCrcNow == 16'h0000); // residue over data plus crc is zero

	// substitute the status word for the crc bytes only when hardware crc is on
	always_comb begin
		rxOut_next.valid = rxIn.valid;
		rxOut_next.last = rxEnd;
		rxOut_next.data = rxIn.data; // see R12, R06
		if (hwCrc && rxPos_reg != 7'd0) begin
			if (rxEnd) begin
				rxOut_next.data[7] = crcOk; // see R11
				if (appendSel) begin
					rxOut_next.data[6:0] = rxInfo.source_match_result_index; // see R08
				end else begin
					rxOut_next.data[6:0] = rxInfo.correlation; // see R07
				end
			end else if (rxPos_reg == rxLen_reg - 7'd1) begin
				rxOut_next.data = rxInfo.rssi; // see R07, R08
			end
		end
	end

	// receive position and running crc
	always_ff @(posedge mclk) begin
		if (rst) begin
			rxPos_reg <= '0;
			rxLen_reg <= '0;
			rxCrc_reg <= '0;
			rxOut <= '0;
		end else begin
			rxOut <= rxOut_next;
			if (rxIn.valid) begin
				if (rxPos_reg == 7'd0) begin
					rxLen_reg <= rxIn.data[6:0];
					rxPos_reg <= (rxIn.data[6:0] != 7'd0) ? 7'd1 : 7'd0;
					rxCrc_reg <= '0;
				end else if (rxEnd) begin
					rxPos_reg <= '0;
				end else begin
					rxPos_reg <= rxPos_reg + 7'd1;
					rxCrc_reg <= rxCrcNow;
				end
			end
		end
	end

	// transmit side: one byte per request, from the fifo, the crc, or the prbs
	always_comb begin
		txOut_next = '0;
		txFifoPop = 1'b0;
		txUnder = 1'b0;
		txPos_next = txPos_reg;
		txLen_next = txLen_reg;
		txCrc_next = txCrc_reg;
		if (txByteReq) begin
			txOut_next.valid = 1'b1;
			if (txMode == frame_ctrl_pkg::TX_PRBS) begin
				// a zero state would lock the generator, so reseed it
				txCrc_next = crc_step((txCrc_reg == 16'h0000) ? frame_ctrl_pkg::PRBS_SEED
					: txCrc_reg, 8'h00); // see R17
				txOut_next.data = txCrc_next[7:0];
			end else if (txMode == frame_ctrl_pkg::TX_LOOP) begin
				// fifo reads cyclically outside; an empty fifo is not an error here
				txFifoPop = transmit_fifo.valid; // see R17
				txOut_next.data = transmit_fifo.data;
			end else if (hwCrc && txPos_reg != 7'd0 && txPos_reg >= txLen_reg - 7'd1) begin
				// crc bytes come from here, low byte first; the fifo is not read
				if (txPos_reg == txLen_reg) begin
					txOut_next.data = txCrc_reg[15:8]; // see R09
					txOut_next.last = 1'b1;
					txPos_next = '0;
				end else begin
					txOut_next.data = txCrc_reg[7:0]; // see R09
					txPos_next = txPos_reg + 7'd1;
				end
			end else if (!transmit_fifo.valid) begin
				txOut_next.valid = 1'b0;
				txUnder = 1'b1; // see R10
				txPos_next = '0;
			end else begin
				txFifoPop = 1'b1;
				txOut_next.data = transmit_fifo.data;
				if (txPos_reg == 7'd0) begin
					txLen_next = transmit_fifo.data[6:0];
					txPos_next = (transmit_fifo.data[6:0] != 7'd0) ? 7'd1 : 7'd0;
					txCrc_next = '0;
				end else if (txPos_reg == txLen_reg) begin
					txOut_next.last = 1'b1;
					txPos_next = '0;
				end else begin
					txCrc_next = crc_step(txCrc_reg, transmit_fifo.data);
					txPos_next = txPos_reg + 7'd1;
				end
			end
		end
	end

	// transmit state
	always_ff @(posedge mclk) begin
		if (rst) begin
			txPos_reg <= '0;
			txLen_reg <= '0;
			txCrc_reg <= '0;
			txOut <= '0;
		end else begin
			txPos_reg <= txPos_next;
			txLen_reg <= txLen_next;
			txCrc_reg <= txCrc_next;
			txOut <= txOut_next;
		end
	end

	// auto ack timer; the crc check here runs whatever the hardware crc bit says
	assign ackArm = rxEnd & autoAck & rxInfo.accepted & rxInfo.ackRequested & crcOk; // see R14, R13
	assign ackFire = (ackCount_reg == 32'h0000_0001);

	// counts down from the ack delay, pulses ackStart as it expires
	always_ff @(posedge mclk) begin
		if (rst) begin
			ackCount_reg <= '0;
			ackStart <= 1'b0;
		end else begin
			ackStart <= ackFire; // see R14
			if (ackArm) begin
				ackCount_reg <= 32'(ACK_CYCLES);
			end else if (ackCount_reg != 32'h0000_0000) begin
				ackCount_reg <= ackCount_reg - 32'h0000_0001;
			end
		end
	end

	// events that feed the sticky status
	assign irqEvent[frame_ctrl_pkg::IRQ_RX_DONE] = rxEnd;
	assign irqEvent[frame_ctrl_pkg::IRQ_CRC_FAIL] = rxEnd & ~crcOk;
	assign irqEvent[frame_ctrl_pkg::IRQ_TX_UNDERFLOW] = txUnder;
	assign irqEvent[frame_ctrl_pkg::IRQ_ACK] = ackFire;

	// checks
	sequence ext_low_odd_write;
		busWrite && idx == frame_ctrl_pkg::IDX_EXT_LOW && wrByte == 8'hAA;
	endsequence

	chk_ext_dup_read: assert property (@(posedge mclk) disable iff (rst) // see R04
		ack_o && !we_i && idx <= frame_ctrl_pkg::IDX_EXT_HIGH
		|-> dat_o[7:0] == {{2{dat_o[6]}}, {2{dat_o[4]}}, {2{dat_o[2]}}, {2{dat_o[0]}}})
		else $error("enable pair bits differ on read");

	chk_ext_odd_ignored: assert property (@(posedge mclk) disable iff (rst) // see R03
		ext_low_odd_write |=> extEnable_reg[3:0] == 4'h0)
		else $error("odd enable bits were stored");

	chk_rx_pass_through: assert property (@(posedge mclk) disable iff (rst) // see R12
		rxIn.valid && !hwCrc |=> rxOut.valid && rxOut.data == $past(rxIn.data))
		else $error("frame byte altered with hardware crc off");

	chk_rx_status_byte: assert property (@(posedge mclk) disable iff (rst) // see R11
		rxEnd && hwCrc |=> rxOut.last && rxOut.data[7] == $past(crcOk))
		else $error("status byte lacks crc pass flag");

	chk_rx_append_sel: assert property (@(posedge mclk) disable iff (rst) // see R08
		rxEnd && hwCrc && appendSel |=> rxOut.data[6:0] == $past(rxInfo.source_match_result_index))
		else $error("match index not appended");

	chk_tx_crc_nopop: assert property (@(posedge mclk) disable iff (rst) // see R09
		txByteReq && hwCrc && txMode == frame_ctrl_pkg::TX_NORMAL && txPos_reg != 7'd0
		&& txPos_reg >= txLen_reg - 7'd1 |-> !txFifoPop ##1 txOut.data == $past(txPos_reg ==
		txLen_reg ? txCrc_reg[15:8] : txCrc_reg[7:0]))
		else $error("crc byte not generated");

	chk_tx_underflow: assert property (@(posedge mclk) disable iff (rst) // see R10
		txByteReq && !transmit_fifo.valid && txMode == frame_ctrl_pkg::TX_NORMAL && !hwCrc
		|=> irqStatus_reg[frame_ctrl_pkg::IRQ_TX_UNDERFLOW] && !txOut.valid)
		else $error("underflow not flagged");

	chk_prbs_no_pop: assert property (@(posedge mclk) disable iff (rst) // see R17
		txByteReq && txMode == frame_ctrl_pkg::TX_PRBS |-> !txFifoPop ##1 txOut.valid)
		else $error("prbs mode read the fifo");

	chk_ack_timer: assert property (@(posedge mclk) disable iff (rst) // see R14
		ackArm |=> ackCount_reg == 32'(ACK_CYCLES) ##1 !ackStart)
		else $error("ack delay not loaded");

	chk_peak_hold: assert property (@(posedge mclk) disable iff (rst) // see R15
		peakHold && peakSel_reg && rssiValid |=> $signed(rssi_reg) >= $signed($past(rssiSample)))
		else $error("peak value dropped below a sample");
endmodule
`default_nettype wire

// ### tb/tx_fifo_model.sv
// transmit fifo model: bytes queued by the host, head shown to the block, popped by it
`default_nettype none
module tx_fifo_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic push,
	input wire logic [7:0] pushData,
	input wire logic txFifoPop,
	output var frame_ctrl_pkg::byte_in_s transmit_fifo
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [16];
	logic [4:0] wrPtr;
	logic [4:0] rdPtr;
	logic notEmpty;
	assign notEmpty = (wrPtr != rdPtr);
	// an empty fifo shows a changed byte, so a read past the end cannot pass unnoticed
	always_comb begin
		transmit_fifo.valid = notEmpty;
		transmit_fifo.data = notEmpty ? mem[rdPtr[3:0]] : ~mem[rdPtr[3:0] - 4'h1];
	end
	// pointers move only on a host push or a block pop
	always @(posedge mclk) begin
		if (rst) begin
			wrPtr <= 5'h00;
			rdPtr <= 5'h00;
		end else begin
			if (push) begin
				mem[wrPtr[3:0]] <= pushData;
				wrPtr <= wrPtr + 5'h01;
			end
			if (txFifoPop && notEmpty) begin
				rdPtr <= rdPtr + 5'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/frame_handling_control_test.sv
// self-checking bench of the frame handling control block
`default_nettype none
module frame_handling_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int ACKC = 20;
	logic mclk = 0, rst = 1, cyc = 0, stb = 0, we = 0, rssiValid = 0, txByteReq = 0;
	logic push = 0, txFifoPop, ackStart, irq, ack, rxLoop, srchOff, txLoop;
	logic [7:0] adr = 8'h00, rssiSample = 8'h00, pushData = 8'h00, q;
	logic [3:0] sel = 4'h0;
	logic [31:0] datI = 32'h0000_0000, datO;
	logic [11:0] extEn;
	logic [15:0] cf;
	frame_ctrl_pkg::byte_in_s rxIn = '0, transmit_fifo;
	frame_ctrl_pkg::rx_info_s rxInfo = '0;
	frame_ctrl_pkg::byte_out_s rxOut, txOut;
	int fail_count = 0, samples_checked = 0, cycles = 0, lastSeen = 0;
	logic [7:0] capQ [$];
	always #2 mclk = ~mclk;
	frame_handling_control #(.ACK_CYCLES(ACKC)) dut_u (.mclk(mclk), .rst(rst), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datI), .dat_o(datO),
		.ack_o(ack), .rxIn(rxIn), .rxInfo(rxInfo), .rxOut(rxOut), .rssiValid(rssiValid),
		.rssiSample(rssiSample), .transmit_fifo(transmit_fifo), .txFifoPop(txFifoPop),
		.txByteReq(txByteReq), .txOut(txOut), .extMatchEnable(extEn), .rxFifoLoop(rxLoop),
		.symbolSearchOff(srchOff), .txFifoLoop(txLoop), .ackStart(ackStart), .irq(irq));
	tx_fifo_model fifo_u (.mclk(mclk), .rst(rst), .push(push), .pushData(pushData),
		.txFifoPop(txFifoPop), .transmit_fifo(transmit_fifo));
	// both byte streams land in one capture queue; no test runs them together
	always @(posedge mclk) begin
		if (rxOut.valid === 1'b1) capQ.push_back(rxOut.data);
		if (txOut.valid === 1'b1) capQ.push_back(txOut.data);
		if (rxOut.valid === 1'b1 && rxOut.last === 1'b1) lastSeen++;
		if (txOut.valid === 1'b1 && txOut.last === 1'b1) lastSeen++;
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one classic cycle; the bench timeout bounds the wait for ack
	task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		sel <= 4'hF;
		datI <= {24'h00_0000, d};
		do @(posedge mclk); while (ack !== 1'b1);
		q = datO[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
		end
		return c;
	endfunction
	task automatic expect_bytes(input string nm, input logic [7:0] e [4]);
		repeat (3) @(posedge mclk);
		chk({nm, " count"}, capQ.size(), 4);
		for (int i = 0; i < 4 && i < capQ.size(); i++) chk(nm, capQ[i], e[i]);
		chk({nm, " last"}, lastSeen, 1);
		lastSeen = 0;
		capQ.delete();
	endtask
	// frame: length 3, one payload byte, crc low, crc high (optionally spoiled)
	task automatic rx_frame(input logic [7:0] fc, input logic bad, input logic [7:0] e [4]);
		logic [7:0] f [4];
		f = '{8'h03, 8'h5A, cf[7:0], cf[15:8] ^ {7'h00, bad}};
		wb(1, frame_ctrl_pkg::IDX_FRAME_CTRL, fc);
		foreach (f[i]) begin
			@(posedge mclk);
			rxIn <= {1'b1, f[i]};
		end
		@(posedge mclk);
		rxIn <= '0;
		expect_bytes("rx byte", e);
	endtask
	task automatic test_reset_map();
		logic [5:0] idx [5] = '{frame_ctrl_pkg::IDX_EXT_LOW, frame_ctrl_pkg::IDX_EXT_MID,
			frame_ctrl_pkg::IDX_EXT_HIGH, frame_ctrl_pkg::IDX_FRAME_CTRL, 6'h3F};
		logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
		foreach (idx[i]) begin
			wb(0, idx[i], 8'h00);
			chk("reset value", q, rv[i]);
		end
		wb(0, frame_ctrl_pkg::IDX_RSSI, 8'h00);
		chk("rssi reset", q, 8'h80);
	endtask
	task automatic test_ext_enable();
		// odd bits alone must not enable anything
		wb(1, frame_ctrl_pkg::IDX_EXT_LOW, 8'hAA);
		// entry 0 is disabled before its table slot is rewritten
		wb(1, frame_ctrl_pkg::IDX_EXT_LOW, 8'h00);
		wb(1, frame_ctrl_pkg::IDX_EXT_LOW, 8'h55);
		wb(1, frame_ctrl_pkg::IDX_EXT_MID, 8'hAA);
		wb(1, frame_ctrl_pkg::IDX_EXT_HIGH, 8'h41);
		wb(0, frame_ctrl_pkg::IDX_EXT_LOW, 8'h00);
		chk("ext low", q, 8'hFF);
		wb(0, frame_ctrl_pkg::IDX_EXT_MID, 8'h00);
		chk("ext mid", q, 8'h00);
		wb(0, frame_ctrl_pkg::IDX_EXT_HIGH, 8'h00);
		chk("ext high", q, 8'hC3);
		chk("ext entries", extEn, 12'h90F);
	endtask
	task automatic test_rx();
		cf = crc_byte(16'h0000, 8'h5A);
		rxInfo <= '{rssi: 8'hC4, correlation: 7'h2B, source_match_result_index: 7'h05, accepted: 1'b0,
			ackRequested: 1'b0};
		wb(1, frame_ctrl_pkg::IDX_IRQ_MASK, 8'h01);
		rx_frame(8'h40, 0, '{8'h03, 8'h5A, 8'hC4, 8'hAB});
		chk("irq rx done", irq, 1'b1);
		wb(1, frame_ctrl_pkg::IDX_IRQ_STATUS, 8'h01);
		@(posedge mclk);
		chk("irq cleared", irq, 1'b0);
		rx_frame(8'hC0, 0, '{8'h03, 8'h5A, 8'hC4, 8'h85});
		rx_frame(8'h40, 1, '{8'h03, 8'h5A, 8'hC4, 8'h2B});
		wb(0, frame_ctrl_pkg::IDX_IRQ_STATUS, 8'h00);
		chk("crc fail flag", q[1], 1'b1);
		rx_frame(8'h80, 0, '{8'h03, 8'h5A, cf[7:0], cf[15:8]});
	endtask
	// auto ack must follow a good accepted frame with crc on and with crc off alike
	task automatic test_auto_ack();
		logic [7:0] fcs [2] = '{8'h60, 8'h20};
		int n;
		rxInfo.accepted <= 1'b1;
		rxInfo.ackRequested <= 1'b1;
		foreach (fcs[i]) begin
			rx_frame(fcs[i], 0, '{8'h03, 8'h5A, (i == 0) ? 8'hC4 : cf[7:0],
				(i == 0) ? 8'hAB : cf[15:8]});
			n = 0;
			while (ackStart !== 1'b1 && n < 40) begin
				@(posedge mclk);
				n++;
			end
			chk("ack delay", (n >= ACKC - 8 && n <= ACKC + 4), 1'b1);
		end
	endtask
	task automatic tx_run(input int nReq, input logic [7:0] e [4], input logic under);
		repeat (nReq) begin
			@(posedge mclk);
			txByteReq <= 1'b1;
		end
		@(posedge mclk);
		txByteReq <= 1'b0;
		if (under) begin
			repeat (3) @(posedge mclk);
			chk("underflow no byte", capQ.size(), 0);
		end else expect_bytes("tx byte", e);
	endtask
	task automatic fifo_put(input logic [7:0] b);
		@(posedge mclk);
		push <= 1'b1;
		pushData <= b;
		@(posedge mclk);
		push <= 1'b0;
	endtask
	task automatic test_tx();
		logic [15:0] tc;
		tc = crc_byte(16'h0000, 8'h11);
		wb(1, frame_ctrl_pkg::IDX_FRAME_CTRL, 8'h40);
		fifo_put(8'h03);
		fifo_put(8'h11);
		tx_run(4, '{8'h03, 8'h11, tc[7:0], tc[15:8]}, 0);
		wb(1, frame_ctrl_pkg::IDX_FRAME_CTRL, 8'h00);
		// with crc off the host writes every byte itself, check bytes included
		for (int i = 0; i < 4; i++) fifo_put((i == 0) ? 8'h03 : 8'h20 + i[7:0]);
		tx_run(4, '{8'h03, 8'h21, 8'h22, 8'h23}, 0);
		tx_run(1, '{8'h00, 8'h00, 8'h00, 8'h00}, 1);
		wb(0, frame_ctrl_pkg::IDX_IRQ_STATUS, 8'h00);
		chk("tx underflow", q[2], 1'b1);
	endtask
	task automatic test_modes();
		logic [7:0] fc [4] = '{8'h08, 8'h0C, 8'h02, 8'h03};
		logic [2:0] ex [4] = '{3'b100, 3'b010, 3'b001, 3'b000};
		foreach (fc[i]) begin
			wb(1, frame_ctrl_pkg::IDX_FRAME_CTRL, fc[i]);
			// the write lands on the ack edge, so look one edge later
			@(posedge mclk);
			chk("mode outputs", {rxLoop, srchOff, txLoop}, ex[i]);
		end
		// pseudo-random mode answers although the fifo is empty; normal mode would not
		@(posedge mclk);
		txByteReq <= 1'b1;
		@(posedge mclk);
		txByteReq <= 1'b0;
		repeat (3) @(posedge mclk);
		chk("prbs byte count", capQ.size(), 1);
		capQ.delete();
	endtask
	task automatic rssi_put(input logic [7:0] s);
		@(posedge mclk);
		rssiValid <= 1'b1;
		rssiSample <= s;
		@(posedge mclk);
		rssiValid <= 1'b0;
	endtask
	task automatic test_rssi();
		wb(1, frame_ctrl_pkg::IDX_FRAME_CTRL, 8'h40);
		rssi_put(8'h10);
		rssi_put(8'hF0);
		wb(0, frame_ctrl_pkg::IDX_RSSI, 8'h00);
		chk("rssi latest", q, 8'hF0);
		wb(1, frame_ctrl_pkg::IDX_FRAME_CTRL, 8'h50);
		rssi_put(8'h05);
		rssi_put(8'h20);
		rssi_put(8'h08);
		wb(0, frame_ctrl_pkg::IDX_RSSI, 8'h00);
		chk("rssi peak", q, 8'h20);
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		test_reset_map();
		test_ext_enable();
		test_rx();
		test_auto_ack();
		test_tx();
		test_modes();
		test_rssi();
		wrap_up();
	end
endmodule
`default_nettype wire
